// ===== rtl/pmr_pkg.sv
// Purpose: Shared constants and types for the supply-management registers
// Assumes: Core clock of 50 MHz, byte-wide special-function-register port
// Notes: Offsets are byte addresses in the core's register space
package pmr_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00_C5;
  localparam logic [7:0] ADDR_WRITE_KEY = 8'h00_C1;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h00_EC;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_CONFIG = 8'h00_F4;
  localparam logic [7:0] ADDR_BACKUP_SWITCH = 8'h00_F5;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h00_F8;
  localparam logic [7:0] ADDR_SCRATCH_ONE = 8'h00_FB;
  localparam logic [7:0] ADDR_SCRATCH_TWO = 8'h00_FC;
  localparam logic [7:0] ADDR_SCRATCH_THREE = 8'h00_FD;
  localparam logic [7:0] ADDR_SCRATCH_FOUR = 8'h00_FE;
  localparam logic [7:0] ADDR_IRQ_PIN_CONFIG = 8'h00_FF;

  // Unlock value for the key register
  localparam logic [7:0] KEY_UNLOCK = 8'h00_EA;
  localparam logic [7:0] RESET_BYTE = 8'h00_00;
  localparam logic [7:0] ALL_ONES = 8'h00_FF;

  // Event flag positions
  localparam int FLAG_RESTORED = 7;
  localparam int FLAG_SAVING_IRQ = 6;
  localparam int FLAG_DIP = 5;
  localparam int FLAG_RESERVED = 4;
  localparam int FLAG_DC_CONVERTER = 3;
  localparam int FLAG_BACKUP_MON = 2;
  localparam int FLAG_SWITCHOVER = 1;
  localparam int FLAG_DC_LOW = 0;

  // Writable bits of the flag and enable registers
  localparam logic [7:0] FLAG_MASK = 8'h00_EF;
  localparam logic [7:0] ENABLE_MASK = 8'h00_AF;
  // Interrupt-pin config: bit 4 reserved, reads zero
  localparam logic [7:0] IRQ_PIN_MASK = 8'h00_EF;
  // Switchover config: only the policy field is stored
  localparam logic [7:0] POLICY_MASK = 8'h00_03;

  // Interrupt-pin config field positions
  localparam int CAL_EN_BIT = 7;
  localparam int CAL_SEL_HI = 6;
  localparam int CAL_SEL_LO = 5;
  localparam int IRQ1_EN_BIT = 3;
  localparam int IRQ1_FN_HI = 2;
  localparam int IRQ1_FN_LO = 1;
  localparam int IRQ0_EN_BIT = 0;

  // Low two bits of the external interrupt 1 function
  localparam logic [1:0] IRQ1_FN_GPIO = 2'h0;
  localparam logic [1:0] IRQ1_FN_BACKUP = 2'h1;

  // Switchover policy codes
  localparam logic [1:0] POLICY_LOW_MAIN = 2'h0;
  localparam logic [1:0] POLICY_MAIN_OR_DC = 2'h1;
  localparam int POLICY_OFF_BIT = 1;

  // Calibration select codes
  localparam logic [1:0] CAL_SEL_1HZ = 2'h0;
  localparam logic [1:0] CAL_SEL_512HZ = 2'h1;
  localparam logic [1:0] CAL_SEL_500HZ = 2'h2;
  localparam logic [1:0] CAL_SEL_16KHZ = 2'h3;

  // Clock and calibration timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CAL_HZ_1 = 1;
  localparam int CAL_HZ_512 = 512;
  localparam int CAL_HZ_500 = 500;
  localparam int CAL_HZ_16K = 16_000;
  localparam int CAL_WINDOW_LONG_MS = 30_500;
  localparam int CAL_WINDOW_SHORT_US = 244_000;
  localparam int CAL_CNT_W = 26;

  // Raw supply event inputs from the analog monitors
  typedef struct packed {
    logic main_source;
    logic sag;
    logic dc_step;
    logic dc_ready;
    logic backup_low;
    logic backup_ready;
    logic dc_low;
  } pmr_event_in_type;

  localparam int EVT_IN_W = 7;
  // Main supply is the source after reset
  localparam logic [6:0] EVT_IN_RESET = 7'h40;

endpackage : pmr_pkg

// ===== rtl/pmr_sync.sv
// Purpose: Two-flop synchroniser for the analog event inputs
// Assumes: Inputs are asynchronous levels held for several clock periods
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module pmr_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  //////////////////////////////////////////////////////////////////////////
  // One pair of flops per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          meta_reg <= RESET_VAL[g];
          stable_reg <= RESET_VAL[g];
        end
        else
        begin
          meta_reg <= async_in[g];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[g] = stable_reg;
    end
  endgenerate

endmodule : pmr_sync

// ===== rtl/pmr_top.sv
// Purpose: Supply-management register bank with event flags and cal output
// Assumes: Byte register port on clk_sys, analog events asynchronous
// Notes: Read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
module pmr_top #(
  parameter int CAL_HALF_1HZ = pmr_pkg::CLK_HZ / (2 * pmr_pkg::CAL_HZ_1),
  parameter int CAL_HALF_512HZ = pmr_pkg::CLK_HZ / (2 * pmr_pkg::CAL_HZ_512),
  parameter int CAL_HALF_500HZ = pmr_pkg::CLK_HZ / (2 * pmr_pkg::CAL_HZ_500),
  parameter int CAL_HALF_16KHZ = pmr_pkg::CLK_HZ / (2 * pmr_pkg::CAL_HZ_16K)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd_en,
  output logic [7:0] sfr_rdata,
  input wire pmr_pkg::pmr_event_in_type supply_evt,
  output logic calib_out,
  output logic calib_out_oe,
  output logic calib_window_short,
  output logic irq1_gpio_sel,
  output logic irq1_backup_ctrl_sel,
  output logic irq1_input_en,
  output logic irq0_input_en,
  output logic switch_on_low_main,
  output logic switch_on_low_dc,
  output logic saving_mode_irq,
  output logic [7:0] power_control_out,
  output logic [7:0] peripheral_config_out
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and wires
  localparam int CAL_CNT_W_L = pmr_pkg::CAL_CNT_W;
  logic [7:0] power_control_reg;
  logic [7:0] write_key_reg;
  logic [7:0] event_enable_reg;
  logic [7:0] peripheral_config_config_reg;
  logic [7:0] backup_switch_reg;
  logic [7:0] event_flags_reg;
  logic [7:0] event_flags_next;
  logic [7:0] scratch_one_reg;
  logic [7:0] scratch_two_reg;
  logic [7:0] scratch_three_reg;
  logic [7:0] scratch_four_reg;
  logic [7:0] irq_pin_reg;
  logic [7:0] rdata_reg;
  logic [6:0] evt_sync;
  logic [6:0] evt_prev_reg;
  logic [CAL_CNT_W_L-1:0] cal_cnt_reg;
  logic [CAL_CNT_W_L-1:0] cal_cnt_next;
  logic [CAL_CNT_W_L-1:0] cal_half;
  logic cal_out_reg;
  logic cal_oe_reg;
  logic cal_short_reg;
  logic irq1_gpio_reg;
  logic irq1_backup_reg;
  logic irq1_en_reg;
  logic irq0_en_reg;
  logic sw_main_reg;
  logic sw_dc_reg;

  //////////////////////////////////////////////////////////////////////////
  // Synchronise the analog event inputs
  pmr_sync #(
    .WIDTH(pmr_pkg::EVT_IN_W),
    .RESET_VAL(pmr_pkg::EVT_IN_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(supply_evt),
    .sync_out(evt_sync)
  );

  pmr_pkg::pmr_event_in_type evt_now;
  pmr_pkg::pmr_event_in_type evt_old;
  assign evt_now = evt_sync;
  assign evt_old = evt_prev_reg;

  // Edge history for event detection
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      evt_prev_reg <= pmr_pkg::EVT_IN_RESET;
    else
      evt_prev_reg <= evt_sync;
  end

  //////////////////////////////////////////////////////////////////////////
  // Address decode
  wire hit_power = (sfr_addr == pmr_pkg::ADDR_POWER_CONTROL);
  wire hit_key = (sfr_addr == pmr_pkg::ADDR_WRITE_KEY);
  wire hit_enable = (sfr_addr == pmr_pkg::ADDR_EVENT_ENABLE);
  wire hit_peripheral_config = (sfr_addr == pmr_pkg::ADDR_PERIPHERAL_CONFIG_CONFIG);
  wire hit_switch = (sfr_addr == pmr_pkg::ADDR_BACKUP_SWITCH);
  wire hit_flags = (sfr_addr == pmr_pkg::ADDR_EVENT_FLAGS);
  wire hit_scr1 = (sfr_addr == pmr_pkg::ADDR_SCRATCH_ONE);
  wire hit_scr2 = (sfr_addr == pmr_pkg::ADDR_SCRATCH_TWO);
  wire hit_scr3 = (sfr_addr == pmr_pkg::ADDR_SCRATCH_THREE);
  wire hit_scr4 = (sfr_addr == pmr_pkg::ADDR_SCRATCH_FOUR);
  wire hit_irq_pin = (sfr_addr == pmr_pkg::ADDR_IRQ_PIN_CONFIG);
  wire key_open = (write_key_reg == pmr_pkg::KEY_UNLOCK);
  wire wr_irq_pin = sfr_wr_en && hit_irq_pin && key_open;
  wire wr_flags = sfr_wr_en && hit_flags;

  //////////////////////////////////////////////////////////////////////////
  // Supply events, one cycle pulses
  wire ev_restored = evt_now.main_source && !evt_old.main_source;
  wire ev_switchover = !evt_now.main_source && evt_old.main_source;
  wire ev_sag = evt_now.sag && !evt_old.sag;
  wire ev_dc_conv = (evt_now.dc_step && !evt_old.dc_step) ||
                    (evt_now.dc_ready && !evt_old.dc_ready);
  wire ev_backup = (evt_now.backup_low && !evt_old.backup_low) ||
                   (evt_now.backup_ready && !evt_old.backup_ready);
  wire ev_dc_low = evt_now.dc_low && !evt_old.dc_low;

  wire [7:0] ev_vec = {ev_restored, 1'b0, ev_sag, 1'b0, ev_dc_conv,
                       ev_backup, ev_switchover, ev_dc_low};
  wire saving_hit = |(ev_vec & event_enable_reg);
  wire [7:0] ev_all = ev_vec | ({7'h00, saving_hit} << pmr_pkg::FLAG_SAVING_IRQ);
  wire [7:0] keep_mask = wr_flags ? sfr_wdata : pmr_pkg::ALL_ONES;
  assign event_flags_next = ((event_flags_reg & keep_mask) | ev_all) &
                            pmr_pkg::FLAG_MASK;

  //////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      power_control_reg <= pmr_pkg::RESET_BYTE;
      write_key_reg <= pmr_pkg::RESET_BYTE;
      event_enable_reg <= pmr_pkg::RESET_BYTE;
      peripheral_config_config_reg <= pmr_pkg::RESET_BYTE;
      backup_switch_reg <= pmr_pkg::RESET_BYTE;
      event_flags_reg <= pmr_pkg::RESET_BYTE;
      scratch_one_reg <= pmr_pkg::RESET_BYTE;
      scratch_two_reg <= pmr_pkg::RESET_BYTE;
      scratch_three_reg <= pmr_pkg::RESET_BYTE;
      scratch_four_reg <= pmr_pkg::RESET_BYTE;
      irq_pin_reg <= pmr_pkg::RESET_BYTE;
    end
    else
    begin
      event_flags_reg <= event_flags_next;
      if (sfr_wr_en && hit_power)
        power_control_reg <= sfr_wdata;
      if (sfr_wr_en && hit_key)
        write_key_reg <= sfr_wdata;
      if (sfr_wr_en && hit_enable)
        event_enable_reg <= sfr_wdata & pmr_pkg::ENABLE_MASK;
      if (sfr_wr_en && hit_peripheral_config)
        peripheral_config_config_reg <= sfr_wdata;
      if (sfr_wr_en && hit_switch)
        backup_switch_reg <= sfr_wdata & pmr_pkg::POLICY_MASK;
      if (sfr_wr_en && hit_scr1)
        scratch_one_reg <= sfr_wdata;
      if (sfr_wr_en && hit_scr2)
        scratch_two_reg <= sfr_wdata;
      if (sfr_wr_en && hit_scr3)
        scratch_three_reg <= sfr_wdata;
      if (sfr_wr_en && hit_scr4)
        scratch_four_reg <= sfr_wdata;
      if (wr_irq_pin)
        irq_pin_reg <= sfr_wdata & pmr_pkg::IRQ_PIN_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped addresses read zero
  wire [7:0] rd_mux =
    hit_power ? power_control_reg :
    hit_key ? write_key_reg :
    hit_enable ? event_enable_reg :
    hit_peripheral_config ? peripheral_config_config_reg :
    hit_switch ? backup_switch_reg :
    hit_flags ? event_flags_reg :
    hit_scr1 ? scratch_one_reg :
    hit_scr2 ? scratch_two_reg :
    hit_scr3 ? scratch_three_reg :
    hit_scr4 ? scratch_four_reg :
    hit_irq_pin ? irq_pin_reg : pmr_pkg::RESET_BYTE;

  // Read data capture
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rdata_reg <= pmr_pkg::RESET_BYTE;
    else if (sfr_rd_en)
      rdata_reg <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin function and policy decode
  wire [1:0] irq1_fn = irq_pin_reg[pmr_pkg::IRQ1_FN_HI:pmr_pkg::IRQ1_FN_LO];
  wire [1:0] policy = backup_switch_reg[1:0];
  wire pol_off = policy[pmr_pkg::POLICY_OFF_BIT];
  wire [1:0] cal_sel = irq_pin_reg[pmr_pkg::CAL_SEL_HI:pmr_pkg::CAL_SEL_LO];

  // Registered decoded controls
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq1_gpio_reg <= 1'b0;
      irq1_backup_reg <= 1'b0;
      irq1_en_reg <= 1'b0;
      irq0_en_reg <= 1'b0;
      sw_main_reg <= 1'b0;
      sw_dc_reg <= 1'b0;
      cal_short_reg <= 1'b0;
    end
    else
    begin
      irq1_gpio_reg <= (irq1_fn == pmr_pkg::IRQ1_FN_GPIO);
      irq1_backup_reg <= (irq1_fn == pmr_pkg::IRQ1_FN_BACKUP);
      irq1_en_reg <= irq_pin_reg[pmr_pkg::IRQ1_EN_BIT];
      irq0_en_reg <= irq_pin_reg[pmr_pkg::IRQ0_EN_BIT];
      sw_main_reg <= !pol_off;
      sw_dc_reg <= !pol_off && (policy == pmr_pkg::POLICY_MAIN_OR_DC);
      cal_short_reg <= cal_sel[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Calibration frequency divider
  // half period per select
  assign cal_half =
    (cal_sel == pmr_pkg::CAL_SEL_1HZ) ? CAL_CNT_W_L'(CAL_HALF_1HZ - 1) :
    (cal_sel == pmr_pkg::CAL_SEL_512HZ) ? CAL_CNT_W_L'(CAL_HALF_512HZ - 1) :
    (cal_sel == pmr_pkg::CAL_SEL_500HZ) ? CAL_CNT_W_L'(CAL_HALF_500HZ - 1) :
    CAL_CNT_W_L'(CAL_HALF_16KHZ - 1);
  wire cal_wrap = (cal_cnt_reg >= cal_half);
  assign cal_cnt_next = cal_wrap ? '0 : cal_cnt_reg + 1'b1;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cal_cnt_reg <= '0;
      cal_out_reg <= 1'b0;
      cal_oe_reg <= 1'b0;
    end
    else
    begin
      cal_oe_reg <= irq_pin_reg[pmr_pkg::CAL_EN_BIT];
      if (!irq_pin_reg[pmr_pkg::CAL_EN_BIT])
      begin
        cal_cnt_reg <= '0;
        cal_out_reg <= 1'b0;
      end
      else
      begin
        cal_cnt_reg <= cal_cnt_next;
        if (cal_wrap)
          cal_out_reg <= !cal_out_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sfr_rdata = rdata_reg;
  assign calib_out = cal_out_reg;
  assign calib_out_oe = cal_oe_reg;
  assign calib_window_short = cal_short_reg;
  assign irq1_gpio_sel = irq1_gpio_reg;
  assign irq1_backup_ctrl_sel = irq1_backup_reg;
  assign irq1_input_en = irq1_en_reg;
  assign irq0_input_en = irq0_en_reg;
  assign switch_on_low_main = sw_main_reg;
  assign switch_on_low_dc = sw_dc_reg;
  assign saving_mode_irq = event_flags_reg[pmr_pkg::FLAG_SAVING_IRQ];
  assign power_control_out = power_control_reg;
  assign peripheral_config_out = peripheral_config_config_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_key_locked: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (sfr_wr_en && hit_irq_pin && !key_open) |=> $stable(irq_pin_reg))
    else $error("locked pin config write took effect");

  a_key_unlocked: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (sfr_wr_en && hit_irq_pin && key_open) |=>
      (irq_pin_reg == ($past(sfr_wdata) & pmr_pkg::IRQ_PIN_MASK)))
    else $error("unlocked pin config write lost");

  a_cal_enable: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(irq_pin_reg[pmr_pkg::CAL_EN_BIT]) |=> calib_out_oe ##1 calib_out_oe)
    else $error("calibration output not driven");

  a_cal_toggle: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ($changed(cal_out_reg) && $past(irq_pin_reg[pmr_pkg::CAL_EN_BIT])) |->
      ($past(cal_cnt_reg) >= $past(cal_half)))
    else $error("calibration toggle off period");

  a_restore_flag: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ev_restored |=> event_flags_reg[pmr_pkg::FLAG_RESTORED])
    else $error("restored flag not set");

  a_saving_flag: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    saving_hit |=> saving_mode_irq)
    else $error("saving-mode flag not set");

  a_event_flags: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (ev_sag || ev_dc_conv || ev_backup || ev_switchover || ev_dc_low) |=>
      ((event_flags_reg & $past(ev_vec)) == $past(ev_vec)))
    else $error("event flag not set");

  a_flag_hold: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (!wr_flags && event_flags_reg[pmr_pkg::FLAG_DIP]) |=>
      event_flags_reg[pmr_pkg::FLAG_DIP])
    else $error("flag dropped without clear");

  a_policy_out: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (sfr_wr_en && hit_switch) |=> ##1
      (switch_on_low_main == !$past(sfr_wdata[1], 2)))
    else $error("switchover policy not applied");

  a_irq0_func: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_irq_pin |=> ##1 (irq0_input_en == $past(sfr_wdata[0], 2)))
    else $error("irq0 function not applied");

endmodule : pmr_top

// ===== dv/pmr_top_tb_top.sv
// Purpose: Self-checking bench for the supply-management register bank
// Assumes: Short calibration half periods are set at the instance
// Notes: Inputs change 1 ns after the rising clock edge
`timescale 1ns/1ps
module pmr_top_tb_top;
  localparam int HALF_A = 8;
  localparam int HALF_B = 6;
  localparam int HALF_C = 5;
  localparam int HALF_D = 4;
  localparam int MAX_CYC = 20_000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00_00;
  logic sfr_wr_en = 1'b0;
  logic [7:0] sfr_wdata = 8'h00_00;
  logic sfr_rd_en = 1'b0;
  logic [7:0] sfr_rdata;
  logic [6:0] evt_vec = pmr_pkg::EVT_IN_RESET;
  logic calib_out;
  logic calib_out_oe;
  logic calib_window_short;
  logic irq1_gpio_sel;
  logic irq1_backup_ctrl_sel;
  logic irq1_input_en;
  logic irq0_input_en;
  logic switch_on_low_main;
  logic switch_on_low_dc;
  logic saving_mode_irq;
  logic [7:0] power_control_out;
  logic [7:0] peripheral_config_out;
  logic [7:0] dec;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  pmr_top #(
    .CAL_HALF_1HZ(HALF_A),
    .CAL_HALF_512HZ(HALF_B),
    .CAL_HALF_500HZ(HALF_C),
    .CAL_HALF_16KHZ(HALF_D)
  ) i_dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en),
    .sfr_wdata(sfr_wdata),
    .sfr_rd_en(sfr_rd_en),
    .sfr_rdata(sfr_rdata),
    .supply_evt(pmr_pkg::pmr_event_in_type'(evt_vec)),
    .calib_out(calib_out),
    .calib_out_oe(calib_out_oe),
    .calib_window_short(calib_window_short),
    .irq1_gpio_sel(irq1_gpio_sel),
    .irq1_backup_ctrl_sel(irq1_backup_ctrl_sel),
    .irq1_input_en(irq1_input_en),
    .irq0_input_en(irq0_input_en),
    .switch_on_low_main(switch_on_low_main),
    .switch_on_low_dc(switch_on_low_dc),
    .saving_mode_irq(saving_mode_irq),
    .power_control_out(power_control_out),
    .peripheral_config_out(peripheral_config_out)
  );

  // Decoded pin-function outputs gathered in one byte
  assign dec = {2'b00, calib_out_oe, calib_window_short, irq1_gpio_sel,
    irq1_backup_ctrl_sel, irq1_input_en, irq0_input_en};

  // Clock generator
  always #10 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == MAX_CYC)
    begin
      num_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    tick(1);
    sfr_wr_en = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    tick(1);
    sfr_rd_en = 1'b0;
    tick(1);
    chk(sfr_rdata, exp);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////
  // Every register reads zero after reset, outputs decode that
  task automatic t_reset();
    logic [7:0] regs[11] = '{8'h00_C5, 8'h00_EC, 8'h00_F4, 8'h00_F5,
      8'h00_F8, 8'h00_FB, 8'h00_FC, 8'h00_FD, 8'h00_FE, 8'h00_FF, 8'h00_C1};
    foreach (regs[i])
      rd_chk(regs[i], 8'h00_00);
    chk(dec, 8'h00_08);
    chk({6'h00, switch_on_low_main, switch_on_low_dc}, 8'h00_02);
  endtask : t_reset

  // Scratch pads back to back, raw registers, unmapped place
  task automatic t_scratch();
    for (int i = 0; i < 4; i++)
      wr(pmr_pkg::ADDR_SCRATCH_ONE + 8'(i), 8'h00_A5 ^ 8'(i));
    for (int i = 0; i < 4; i++)
      rd_chk(pmr_pkg::ADDR_SCRATCH_ONE + 8'(i), 8'h00_A5 ^ 8'(i));
    wr(pmr_pkg::ADDR_POWER_CONTROL, 8'h00_5A);
    wr(pmr_pkg::ADDR_PERIPHERAL_CONFIG_CONFIG, 8'h00_C3);
    wr(8'h00_C0, 8'h00_FF);
    tick(2);
    chk(power_control_out, 8'h00_5A);
    chk(peripheral_config_out, 8'h00_C3);
    rd_chk(8'h00_C0, 8'h00_00);
  endtask : t_scratch

  // Key-protected pin configuration and its decoded fields
  task automatic t_key();
    logic [7:0] wv[5] = '{8'h00_90, 8'h00_ED, 8'h00_8B, 8'h00_81, 8'h00_40};
    logic [7:0] rv[5] = '{8'h00_80, 8'h00_ED, 8'h00_8B, 8'h00_81, 8'h00_40};
    logic [7:0] dv[5] = '{8'h00_28, 8'h00_33, 8'h00_27, 8'h00_29, 8'h00_18};
    wr(pmr_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00_80);
    tick(3);
    rd_chk(pmr_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00_00);
    chk(dec, 8'h00_08);
    foreach (wv[i])
    begin
      wr(pmr_pkg::ADDR_WRITE_KEY, pmr_pkg::KEY_UNLOCK);
      wr(pmr_pkg::ADDR_IRQ_PIN_CONFIG, wv[i]);
      tick(3);
      rd_chk(pmr_pkg::ADDR_IRQ_PIN_CONFIG, rv[i]);
      chk(dec, dv[i]);
    end
    wr(pmr_pkg::ADDR_WRITE_KEY, 8'h00_00);
    wr(pmr_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00_ED);
    tick(3);
    rd_chk(pmr_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00_40);
  endtask : t_key

  task automatic edge_wait(output int n);
    logic prev;
    prev = calib_out;
    n = 0;
    while (calib_out === prev && n < 100)
    begin
      tick(1);
      n++;
    end
  endtask : edge_wait

  // Calibration output half period for every select code
  task automatic t_calib();
    int n;
    int half[4] = '{HALF_A, HALF_B, HALF_C, HALF_D};
    wr(pmr_pkg::ADDR_WRITE_KEY, pmr_pkg::KEY_UNLOCK);
    for (int s = 0; s < 4; s++)
    begin
      wr(pmr_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00_00);
      wr(pmr_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00_80 | 8'(s << 5));
      edge_wait(n);
      edge_wait(n);
      chk(8'(n), 8'(half[s]));
      chk({7'h00, calib_window_short}, 8'(s >> 1));
    end
    wr(pmr_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00_00);
    tick(3);
    chk({6'h00, calib_out, calib_out_oe}, 8'h00_00);
    wr(pmr_pkg::ADDR_WRITE_KEY, 8'h00_00);
  endtask : t_calib

  // Every switchover policy code
  task automatic t_policy();
    for (int p = 0; p < 4; p++)
    begin
      wr(pmr_pkg::ADDR_BACKUP_SWITCH, 8'(p));
      tick(3);
      rd_chk(pmr_pkg::ADDR_BACKUP_SWITCH, 8'(p));
      chk({6'h00, switch_on_low_main, switch_on_low_dc},
        {6'h00, p < 2, p == 1});
    end
  endtask : t_policy

  // Each supply event sets its flag, gated into the saving-mode flag
  task automatic t_events();
    int b;
    int idx[8] = '{5, 4, 3, 2, 1, 0, 6, 6};
    logic [7:0] ef[8] = '{8'h00_20, 8'h00_48, 8'h00_48, 8'h00_44,
      8'h00_44, 8'h00_41, 8'h00_02, 8'h00_C0};
    wr(pmr_pkg::ADDR_EVENT_ENABLE, 8'h00_8D);
    rd_chk(pmr_pkg::ADDR_EVENT_ENABLE, 8'h00_8D);
    foreach (idx[i])
    begin
      b = idx[i];
      evt_vec[b] = ~evt_vec[b];
      tick(4);
      if (b != 6)
        evt_vec[b] = 1'b0;
      tick(6);
      rd_chk(pmr_pkg::ADDR_EVENT_FLAGS, ef[i]);
      chk({7'h00, saving_mode_irq}, {7'h00, ef[i][6]});
      wr(pmr_pkg::ADDR_EVENT_FLAGS, 8'h00_00);
    end
    evt_vec[5] = 1'b1;
    tick(10);
    wr(pmr_pkg::ADDR_EVENT_FLAGS, 8'h00_EF);
    rd_chk(pmr_pkg::ADDR_EVENT_FLAGS, 8'h00_20);
    wr(pmr_pkg::ADDR_EVENT_FLAGS, 8'h00_00);
    rd_chk(pmr_pkg::ADDR_EVENT_FLAGS, 8'h00_00);
  endtask : t_events

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    tick(6);
    sys_rst = 1'b0;
    t_reset();
    t_scratch();
    t_key();
    t_calib();
    t_policy();
    t_events();
    results();
  end

endmodule : pmr_top_tb_top
